// File: design/fsrg_defines.vh
// Purpose: Constants of the fan-speed regulator core.
// Assumes: Registers on a plain address/strobe port, byte data.
// Notes:   Offsets are word indices on the register port.
`ifndef FSRG_DEFINES_VH
`define FSRG_DEFINES_VH
`define FSRG_ADDR_W        4
`define FSRG_REG_SPEED     4'h0
`define FSRG_REG_CONFIG    4'h2
`define FSRG_REG_GPIO_DEF  4'h4
`define FSRG_REG_DRIVE     4'h6
`define FSRG_REG_COUNT_T   4'h8
`define FSRG_REG_ALARM_EN  4'h9
`define FSRG_REG_ALARM_ST  4'ha
`define FSRG_REG_TACH      4'hc
`define FSRG_REG_GPIO_ST   4'hd
`define FSRG_CFG_PSC_LSB   0
`define FSRG_CFG_MODE_LSB  4
`define FSRG_DEF_ALERT_LSB 0
`define FSRG_DEF_FON_LSB   2
`define FSRG_DEF_SYNC_LSB  4
`define FSRG_DEF_IO_A_BIT  6
`define FSRG_DEF_IO_B_BIT  7
`define FSRG_BASE_LAST     7'h7f
`define FSRG_MS_LAST       10'h3e7
`define FSRG_MODE_FULL_ON  2'b00
`define FSRG_MODE_FULL_OFF 2'b01
`define FSRG_MODE_CLOSED   2'b10
`define FSRG_MODE_OPEN     2'b11
`define FSRG_RST_CONFIG    8'h0a
`define FSRG_RST_GPIO_DEF  8'hff
`define FSRG_RST_SPEED     8'hff
`define FSRG_RST_DRIVE     8'h00
`define FSRG_RST_COUNT_T   8'h02
`define FSRG_RST_ALARM_EN  8'h00
`define FSRG_BASE_DIV      128
`define FSRG_OSC_KHZ       254
`define FSRG_CLK_KHZ       125000
`define FSRG_ALM_MIN       0
`define FSRG_ALM_MAX       1
`define FSRG_ALM_OVF       2
`define FSRG_ALM_FON       3
`define FSRG_ALM_SYNC      4
`endif

// File: design/fsrg_core.v
// Purpose: Fan-speed regulation, tach counting and pin control core.
// Assumes: One 125 MHz clock; pins are open drain with external pull-ups.
// Notes:   Drive value 00h means full fan voltage, ffh means none.
// Summary of operation
// - Divide regulation clock by 128 for base.
// - Divide base by speed value plus one.
// - Closed loop matches prescaled tach to reference.
// - Slow tach raises fan voltage.
// - Clock source internal oscillator or external clock.
// - Config bits 2..0 select tach prescaler.
// - Mode 10 selects closed loop.
// - Mode 00 is software full on.
// - Mode 01 is full off.
// - Mode 11 follows host drive value.
// - Target speed register is eight bits.
// - Count raw tach pulses in eight bits.
// - Counter saturates, reported count reads 255.
// - Count interval set by count-time register.
// - Primary count ignores the prescaler.
// - Overflow raises alert when enabled.
// - Host programs all pin modes.
// - Plain pins: 0 drives low, 1 releases.
// - Two-bit pins: 10 low, 11 released.
// - All pins released after reset.
// - Status register reports real pin levels.
// - Alert pin definition 01 makes alert output.
// - Alert pin low on any enabled alarm.
// - Full-on pin definition 01 makes full-on input.
// - Low full-on input forces full voltage.
// - Sync pin 01 clock out, 00 clock in.
`timescale 1ns/10ps
`include "fsrg_defines.vh"
module fsrg_core #(
    parameter OSC_DIV  = 246,
    parameter TICK_DIV = 125000
) (
    input  wire                    clk_i,
    input  wire                    nrst_i,
    input  wire [`FSRG_ADDR_W-1:0] addr_i,
    input  wire [7:0]              wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [7:0]              rdata_o,
    input  wire                    tach_i,
    input  wire [4:0]              pin_i,
    output wire [4:0]              pin_o,
    output wire [4:0]              pin_oe_o,
    output reg  [7:0]              drive_o
);
    // Pin order: 0 alert_capable_pin, 1 full_on_capable_pin, 2 sync_clock_pin,
    // 3 plain_io_pin_a, 4 plain_io_pin_b.
    reg [7:0]  speed_q;
    reg [7:0]  config_q;
    reg [7:0]  gpio_def_q;
    reg [7:0]  drive_reg_q;
    reg [7:0]  count_t_q;
    reg [7:0]  alarm_en_q;
    reg [4:0]  alarm_st_q;
    reg [7:0]  tach_cnt_q;
    reg [7:0]  tach_rep_q;
    reg [4:0]  pin_s1_q, pin_s2_q;
    reg [2:0]  tach_s_q;
    reg        tach_s1_q;
    reg [8:0]  osc_cnt_q;
    reg        osc_q;
    reg        src_d1_q;
    reg [6:0]  base_cnt_q;
    reg [7:0]  ref_cnt_q;
    reg [4:0]  psc_cnt_q;
    reg [15:0] fb_cnt_q;
    reg [16:0] tick_cnt_q;
    reg [7:0]  sec_cnt_q;
    reg        clr_pend_q;

    // Mode field codes: 00 full on, 01 full off, 10 closed loop, 11 open loop.
    wire [1:0] mode      = config_q[`FSRG_CFG_MODE_LSB+1:`FSRG_CFG_MODE_LSB];
    wire [2:0] psc_code  = config_q[`FSRG_CFG_PSC_LSB+2:`FSRG_CFG_PSC_LSB];
    wire [1:0] def_alert = gpio_def_q[`FSRG_DEF_ALERT_LSB+1:`FSRG_DEF_ALERT_LSB];
    wire [1:0] def_fon   = gpio_def_q[`FSRG_DEF_FON_LSB+1:`FSRG_DEF_FON_LSB];
    wire [1:0] def_sync  = gpio_def_q[`FSRG_DEF_SYNC_LSB+1:`FSRG_DEF_SYNC_LSB];
    wire       def_io_a  = gpio_def_q[`FSRG_DEF_IO_A_BIT];
    wire       def_io_b  = gpio_def_q[`FSRG_DEF_IO_B_BIT];
    wire       tach_rise = tach_s_q[1] & ~tach_s_q[2];

    // Two-bit pin definition decoding shared by three pins.
    function pin_low;
        input [1:0] def;
        begin
            pin_low = (def == 2'b10);
        end
    endfunction

    // Prescaler code to ratio minus one.
    // Codes above four keep the largest ratio rather than wrapping.
    function [4:0] psc_ratio_m1;
        input [2:0] code;
        begin
            case (code)
                3'd0:    psc_ratio_m1 = 5'd0;
                3'd1:    psc_ratio_m1 = 5'd1;
                3'd2:    psc_ratio_m1 = 5'd3;
                3'd3:    psc_ratio_m1 = 5'd7;
                default: psc_ratio_m1 = 5'd15;
            endcase
        end
    endfunction

    // Input synchronisers; the first stage feeds only the second.
    // Pins reset high, their idle level behind the pull-ups, so no false low follows.
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_s1_q  <= 5'h1f;
            pin_s2_q  <= 5'h1f;
            tach_s1_q <= 1'b0;
            tach_s_q  <= 3'b000;
        end else begin
            pin_s1_q  <= pin_i;
            pin_s2_q  <= pin_s1_q;
            tach_s1_q <= tach_i;
            tach_s_q  <= {tach_s_q[1:0], tach_s1_q};
        end
    end

    // Internal oscillator model: toggles every OSC_DIV cycles, near 254 kHz.
    // Its rate sets the sync clock output and, unless the sync pin is an input, the base period.
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            osc_cnt_q <= 9'h000;
            osc_q     <= 1'b0;
        end else if (osc_cnt_q == OSC_DIV[8:0] - 9'h001) begin
            osc_cnt_q <= 9'h000;
            osc_q     <= ~osc_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 9'h001;
        end
    end

    // An external clock only applies when the sync pin is an input.
    wire ext_sel  = (def_sync == 2'b00);
    wire src_lvl  = ext_sel ? pin_s2_q[2] : osc_q;
    wire src_rise = src_lvl & ~src_d1_q;
    wire base_tick = src_rise && (base_cnt_q == `FSRG_BASE_LAST);
    wire ref_tick  = base_tick && (ref_cnt_q >= speed_q);
    // A lowered ratio or speed leaves a count past its end; >= recovers at once.
    wire fb_tick   = tach_rise && (psc_cnt_q >= psc_ratio_m1(psc_code));

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            src_d1_q   <= 1'b0;
            base_cnt_q <= 7'h00;
            ref_cnt_q  <= 8'h00;
            psc_cnt_q  <= 5'h00;
            fb_cnt_q   <= 16'h0000;
        end else begin
            src_d1_q <= src_lvl;
            if (src_rise) begin
                base_cnt_q <= base_cnt_q + 7'h01;
            end
            if (base_tick) begin
                ref_cnt_q <= ref_tick ? 8'h00 : ref_cnt_q + 8'h01;
            end
            if (tach_rise) begin
                psc_cnt_q <= fb_tick ? 5'h00 : psc_cnt_q + 5'h01;
            end
            // Feedback edges seen in the current reference period.
            // The count saturates so a runaway fan cannot wrap to a slow reading.
            if (ref_tick) begin
                fb_cnt_q <= {15'h0000, fb_tick};
            end else if (fb_tick && fb_cnt_q != 16'hffff) begin
                fb_cnt_q <= fb_cnt_q + 16'h0001;
            end
        end
    end

    // Closed-loop drive: one step per reference period; lower code means more volts.
    // One feedback edge per period is the locked state; none or several move a step.
    reg [7:0] loop_q;
    reg [7:0] loop_d;
    always @* begin
        loop_d = loop_q;
        if (mode != `FSRG_MODE_CLOSED) begin
            // Track the applied drive so entry into closed loop is bumpless.
            loop_d = drive_o;
        end else if (ref_tick) begin
            if (fb_cnt_q == 16'h0000 && loop_q != 8'h00) begin
                loop_d = loop_q - 8'h01;
            end else if (fb_cnt_q > 16'h0001 && loop_q != 8'hff) begin
                loop_d = loop_q + 8'h01;
            end
        end
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            loop_q <= `FSRG_RST_DRIVE;
        end else begin
            loop_q <= loop_d;
        end
    end

    // The override lands three cycles after the pin falls, behind its synchroniser.
    wire hw_full_on = (def_fon == 2'b01) && !pin_s2_q[1];
    reg  [7:0] drive_d;
    always @* begin
        case (mode)
            `FSRG_MODE_FULL_ON:  drive_d = 8'h00;
            `FSRG_MODE_FULL_OFF: drive_d = 8'hff;
            `FSRG_MODE_CLOSED:   drive_d = loop_q;
            default:             drive_d = drive_reg_q;
        endcase
        // Applied last so that it beats every software mode.
        if (hw_full_on) begin
            drive_d = 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            drive_o <= `FSRG_RST_DRIVE;
        end else begin
            drive_o <= drive_d;
        end
    end

    // Count interval: count_t seconds, minimum one; a 1 ms tick divides down.
    // TICK_DIV is a parameter so that a bench can shorten the second.
    reg  [9:0] ms_cnt_q;
    wire ms_tick  = (tick_cnt_q == TICK_DIV[16:0] - 17'h00001);
    wire sec_tick = ms_tick && (ms_cnt_q == `FSRG_MS_LAST);
    wire [7:0] t_len = (count_t_q == 8'h00) ? 8'h01 : count_t_q;
    wire win_end  = sec_tick && (sec_cnt_q >= t_len - 8'h01);
    wire ovf      = win_end && (tach_cnt_q == 8'hff);

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            tick_cnt_q <= 17'h00000;
            ms_cnt_q   <= 10'h000;
            sec_cnt_q  <= 8'h00;
        end else begin
            tick_cnt_q <= ms_tick ? 17'h00000 : tick_cnt_q + 17'h00001;
            if (ms_tick) begin
                ms_cnt_q <= sec_tick ? 10'h000 : ms_cnt_q + 10'h001;
            end
            if (sec_tick) begin
                sec_cnt_q <= win_end ? 8'h00 : sec_cnt_q + 8'h01;
            end
        end
    end

    // Raw tach edges, so the prescaler never touches this count.
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            tach_cnt_q <= 8'h00;
            tach_rep_q <= 8'h00;
        end else if (win_end) begin
            // An edge in the closing cycle opens the next window's count.
            tach_rep_q <= tach_cnt_q;
            tach_cnt_q <= {7'h00, tach_rise};
        end else if (tach_rise && tach_cnt_q != 8'hff) begin
            tach_cnt_q <= tach_cnt_q + 8'h01;
        end
    end

    // Alarm conditions; status bits are sticky and set wins over a read clear.
    // A condition that still holds in the clearing cycle sets its bit again.
    wire [4:0] alm_cond;
    assign alm_cond[`FSRG_ALM_MIN]  = (mode == `FSRG_MODE_CLOSED) && loop_q == 8'h00;
    assign alm_cond[`FSRG_ALM_MAX]  = (mode == `FSRG_MODE_CLOSED) && loop_q == 8'hff;
    assign alm_cond[`FSRG_ALM_OVF]  = ovf;
    assign alm_cond[`FSRG_ALM_FON]  = !pin_s2_q[1];
    assign alm_cond[`FSRG_ALM_SYNC] = !pin_s2_q[2];
    wire [4:0] alm_set = alm_cond & alarm_en_q[4:0];

    reg  [4:0] alarm_st_d;
    always @* begin
        if (clr_pend_q) begin
            // Read clears only what is no longer true.
            alarm_st_d = alm_set;
        end else begin
            alarm_st_d = (alarm_st_q & alarm_en_q[4:0]) | alm_set;
        end
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            alarm_st_q <= 5'h00;
        end else begin
            alarm_st_q <= alarm_st_d;
        end
    end

    // Register writes.
    // Read-only and unmapped indices fall into the default and are ignored.
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            speed_q     <= `FSRG_RST_SPEED;
            config_q    <= `FSRG_RST_CONFIG;
            gpio_def_q  <= `FSRG_RST_GPIO_DEF;
            drive_reg_q <= `FSRG_RST_DRIVE;
            count_t_q   <= `FSRG_RST_COUNT_T;
            alarm_en_q  <= `FSRG_RST_ALARM_EN;
        end else if (wr_i) begin
            case (addr_i)
                `FSRG_REG_SPEED:    speed_q     <= wdata_i;
                `FSRG_REG_CONFIG:   config_q    <= wdata_i;
                `FSRG_REG_GPIO_DEF: gpio_def_q  <= wdata_i;
                `FSRG_REG_DRIVE:    drive_reg_q <= wdata_i;
                `FSRG_REG_COUNT_T:  count_t_q   <= wdata_i;
                `FSRG_REG_ALARM_EN: alarm_en_q  <= wdata_i;
                default:            ;
            endcase
        end
    end

    // Register reads: data one cycle after the strobe, zero when unmapped.
    // Status reads show synchronised levels, two cycles behind the pins.
    reg  [7:0] rdata_d;
    always @* begin
        case (addr_i)
            `FSRG_REG_SPEED:    rdata_d = speed_q;
            `FSRG_REG_CONFIG:   rdata_d = config_q;
            `FSRG_REG_GPIO_DEF: rdata_d = gpio_def_q;
            `FSRG_REG_DRIVE:    rdata_d = drive_o;
            `FSRG_REG_COUNT_T:  rdata_d = count_t_q;
            `FSRG_REG_ALARM_EN: rdata_d = alarm_en_q;
            `FSRG_REG_ALARM_ST: rdata_d = {3'b000, alarm_st_q};
            `FSRG_REG_TACH:     rdata_d = tach_rep_q;
            `FSRG_REG_GPIO_ST:  rdata_d = {3'b000, pin_s2_q};
            default:            rdata_d = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o    <= 8'h00;
            clr_pend_q <= 1'b0;
        end else begin
            clr_pend_q <= rd_i && (addr_i == `FSRG_REG_ALARM_ST);
            if (rd_i) begin
                rdata_o <= rdata_d;
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    // Pin drivers: open drain, output always low, enable means pull down.
    // Codes 10 pull and 11 release; the special codes are decoded per pin.
    wire alert_on = (def_alert == 2'b01) && (alarm_st_q != 5'h00);
    reg  [4:0] pull_d;
    always @* begin
        pull_d[0] = pin_low(def_alert);
        pull_d[1] = pin_low(def_fon);
        pull_d[2] = pin_low(def_sync);
        // A full-on input never pulls, so it keeps sensing the external level.
        if (alert_on) begin
            pull_d[0] = 1'b1;
        end
        if (def_sync == 2'b01) begin
            pull_d[2] = ~osc_q;
        end
        pull_d[3] = ~def_io_a;
        pull_d[4] = ~def_io_b;
    end
    assign pin_o    = 5'h00;
    assign pin_oe_o = pull_d;
endmodule

// File: verification/fsrg_fan_model.sv
// Purpose: Fan with tachometer behind the pass transistor.
// Assumes: Lower drive code means more voltage and a faster rotor.
// Notes:   Tach half period is 4 plus the drive code, in clocks.
`timescale 1ns/10ps
module fsrg_fan_model (
    input  wire       clk_i,
    input  wire [7:0] drive_i,
    output logic      tach_o
);
    int cnt;
    initial begin
        tach_o = 1'b1;
        cnt = 0;
    end
    // Code ff removes all voltage, so the rotor stops and the tach line freezes.
    always @(posedge clk_i) begin
        if (drive_i != 8'hff) begin
            cnt = cnt + 1;
            if (cnt >= 4 + drive_i) begin
                cnt = 0;
                tach_o <= ~tach_o;
            end
        end
    end
endmodule

// File: verification/fsrg_core_checker.sv
// Purpose: Port assertions of the regulator core.
// Assumes: Registers change only through the host port.
// Notes:   Shadows config, pin definition and drive registers.
`timescale 1ns/10ps
`include "fsrg_defines.vh"
module fsrg_checker (
    input wire                    clk_i,
    input wire                    nrst_i,
    input wire [`FSRG_ADDR_W-1:0] addr_i,
    input wire [7:0]              wdata_i,
    input wire                    wr_i,
    input wire                    rd_i,
    input wire [7:0]              rdata_o,
    input wire [4:0]              pin_i,
    input wire [4:0]              pin_oe_o,
    input wire [7:0]              drive_o
);
    logic [7:0] cfg_q;
    logic [7:0] def_q;
    logic [7:0] drv_q;
    logic       vld_q;
    wire  [1:0] md  = cfg_q[5:4];
    wire        fon = def_q[3:2] == 2'b01 && !pin_i[1];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Open-loop check waits for a host drive write, since the loop may leave its own value.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cfg_q <= 8'h0a;
            def_q <= 8'hff;
            drv_q <= 8'h00;
            vld_q <= 1'b0;
        end else begin
            if (wr_i && addr_i == `FSRG_REG_CONFIG) cfg_q <= wdata_i;
            if (wr_i && addr_i == `FSRG_REG_GPIO_DEF) def_q <= wdata_i;
            if (wr_i && addr_i == `FSRG_REG_DRIVE) drv_q <= wdata_i;
            vld_q <= md == 2'b11 && (vld_q || wr_i && addr_i == `FSRG_REG_DRIVE);
        end
    end
    chk_unmapped_read: assert property (rd_i && addr_i == 4'h1 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_reset_state: assert property ($rose(nrst_i) |-> pin_oe_o == 5'h00 && drive_o == 8'h00)
        else $error("state after reset wrong");
    chk_full_on: assert property ((md == 2'b00 && !fon) [*5] |-> drive_o == 8'h00)
        else $error("full on drive wrong");
    chk_full_off: assert property ((md == 2'b01 && !fon) [*5] |-> drive_o == 8'hff)
        else $error("full off drive wrong");
    chk_open_drive: assert property ((md == 2'b11 && vld_q && !fon && !wr_i) [*5] |-> drive_o == drv_q)
        else $error("open loop drive wrong");
    chk_force_on: assert property (fon [*5] |-> drive_o == 8'h00)
        else $error("full-on input ignored");
    chk_plain_pins: assert property (pin_oe_o[4:3] == ~def_q[7:6])
        else $error("plain pin enable wrong");
    chk_alert_pin: assert property (def_q[1] |-> pin_oe_o[0] == !def_q[0])
        else $error("alert pin enable wrong");
    chk_fon_pin: assert property (def_q[3] |-> pin_oe_o[1] == !def_q[2])
        else $error("full-on pin enable wrong");
    chk_sync_pin: assert property (def_q[5] |-> pin_oe_o[2] == !def_q[4])
        else $error("sync pin enable wrong");
    chk_loop_step: assert property ((md == 2'b10 && !fon) [*5] |-> drive_o - $past(drive_o) + 8'h01 <= 8'h02)
        else $error("loop step above one");
endmodule
bind fsrg_core fsrg_checker i_chk (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i),
    .pin_oe_o(pin_oe_o), .drive_o(drive_o));

// File: verification/fan_speed_regulator_gpio_tb_top.sv
// Purpose: Self-checking bench of the regulator core.
// Assumes: Shortened oscillator and tick dividers.
// Notes:   Tach counts may differ from the ideal by one pulse.
`timescale 1ns/10ps
module fan_speed_regulator_gpio_tb_top;
    localparam int WIN = 4000;
    logic       clk_i, nrst_i, wr_i, rd_i, tach_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, drive_o, rd_v, d;
    logic [4:0] pin_i, pin_oe_o, ext_low;
    int         err_count, checks, seed, i;
    logic [3:0] ra [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'h1};
    logic [7:0] rv [7] = '{8'hff, 8'h0a, 8'hff, 8'h00, 8'h02, 8'h00, 8'h00};
    // Open-drain pins read low when either side pulls.
    assign pin_i = ~(pin_oe_o | ext_low);
    fsrg_core #(.OSC_DIV(2), .TICK_DIV(4)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .tach_i(tach_i), .pin_i(pin_i), .pin_o(), .pin_oe_o(pin_oe_o), .drive_o(drive_o));
    fsrg_fan_model i_fan (.clk_i(clk_i), .drive_i(drive_o), .tach_o(tach_i));
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input logic [7:0] got, input int lo, input int hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("mismatch t=%0t got %h not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    function automatic int exp_cnt(input logic [7:0] v);
        int n;
        n = (v == 8'hff) ? 0 : WIN / (2 * (4 + v));
        return (n > 255) ? 255 : n;
    endfunction
    task automatic tach_case(input logic [7:0] cfg, input logic [7:0] v);
        reg_wr(4'h6, v);
        reg_wr(4'h2, cfg);
        repeat (3 * WIN) @(posedge clk_i);
        reg_rd(4'hc);
        cmp_rng(rd_v, (exp_cnt(v) > 0) ? exp_cnt(v) - 1 : 0, exp_cnt(v) + 1);
        $display("tach case %h done", cfg);
    endtask
    task automatic loop_case(input logic [2:0] psc, input int lo, input int hi);
        reg_wr(4'h2, 8'h30);
        reg_wr(4'h6, 8'h40);
        repeat (20) @(posedge clk_i);
        reg_wr(4'h2, {5'h04, psc});
        repeat (5120) @(posedge clk_i);
        cmp_rng(drive_o, lo, hi);
        $display("loop case %0d done", psc);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        nrst_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        ext_low = 5'h00;
        err_count = 0;
        checks = 0;
        seed = 60;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (i = 0; i < 7; i++) begin
            reg_rd(ra[i]);
            cmp(rd_v, rv[i]);
        end
        cmp({3'h0, pin_oe_o}, 8'h00);
        $display("reset test done");
        reg_wr(4'h8, 8'h01);
        tach_case(8'h31, 8'hc4);
        cmp(drive_o, 8'hc4);
        tach_case(8'h34, 8'hc4);
        reg_wr(4'h9, 8'h04);
        reg_wr(4'h4, 8'hfd);
        tach_case(8'h01, 8'h00);
        cmp(rd_v, 8'hff);
        cmp({7'h0, pin_oe_o[0]}, 8'h01);
        reg_rd(4'ha);
        cmp(rd_v & 8'h04, 8'h04);
        tach_case(8'h11, 8'hff);
        reg_wr(4'h4, 8'hf7);
        ext_low <= 5'h02;
        repeat (8) @(posedge clk_i);
        cmp(drive_o, 8'h00);
        ext_low <= 5'h00;
        repeat (8) @(posedge clk_i);
        cmp(drive_o, 8'hff);
        ext_low <= 5'h10;
        reg_wr(4'h4, 8'hbb);
        repeat (4) @(posedge clk_i);
        reg_rd(4'hd);
        cmp(rd_v & 8'h1f, 8'h05);
        cmp({3'h0, pin_oe_o}, 8'h0a);
        ext_low <= 5'h00;
        $display("pin test done");
        reg_wr(4'h2, 8'h30);
        for (i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            reg_wr(4'h6, d);
            reg_wr(4'h4, 8'($random(seed)));
            repeat (6) @(posedge clk_i);
            cmp(drive_o, d);
        end
        $display("open loop test done");
        reg_wr(4'h4, 8'hff);
        loop_case(3'h0, 8'h3f, 8'h41);
        reg_wr(4'h0, 8'h00);
        loop_case(3'h0, 8'h41, 8'h4b);
        loop_case(3'h4, 8'h35, 8'h3f);
        loop_case(3'h7, 8'h35, 8'h3f);
        reg_wr(4'h4, 8'hcf);
        ext_low <= 5'h04;
        loop_case(3'h0, 8'h40, 8'h40);
        ext_low <= 5'h00;
        reg_wr(4'h4, 8'hdf);
        #1 d[0] = pin_oe_o[2];
        repeat (2) @(posedge clk_i);
        #1 cmp({7'h00, d[0] ^ pin_oe_o[2]}, 8'h01);
        test_done;
    end
endmodule
